/* pss_pkg.sv */
// package for the port state standby control block
// assumes a single 100 MHz core clock and synchronous active-high reset
package pss_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // entry lead: reset low this many system clocks before standby pin falls
  localparam int RES_LEAD_CYCLES = 10;
  // recovery lead time in ns and its cycle count (least time, rounded up)
  localparam int RECOV_LEAD_NS = 100;
  localparam int RECOV_LEAD_CYCLES = (RECOV_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // axi4-lite register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIR = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_PULL = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_ADDR = 8'h14;
  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SLEEP_BIT = 2;
  localparam int CTRL_SSBY_BIT = 3;
  localparam int CTRL_RAM_ENABLE_BIT_BIT = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0013;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {PSS_MODE_X1, PSS_MODE_X2, PSS_MODE_SINGLE} pss_mode_e;
  typedef enum {PSS_RESET, PSS_HWSTBY, PSS_SWSTBY, PSS_SLEEP, PSS_RUN} pss_state_e;
endpackage

/* pss_pin_cell.sv */
// one general port pin cell: direction, output latch, pull-up and hold
// assumes state codes from the top; all inputs on core_clk_in
module pss_pin_cell (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // control
  input wire logic dir_in,
  input wire logic port_output_latch_in,
  input wire logic pullup_control_bit_in,
  input wire logic hold_in,
  input wire logic float_in,
  // pin
  output logic pin_out,
  output logic pin_oe_out,
  output logic pullup_on_out
);
  logic held_lvl_q;
  logic held_dir_q;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      held_lvl_q <= 1'b0;
      held_dir_q <= 1'b0;
    end else if (!hold_in) begin
      held_lvl_q <= port_output_latch_in;
      held_dir_q <= dir_in;
    end
  end
  always_comb begin
    if (float_in) begin
      pin_oe_out = 1'b0;
      pin_out = 1'b0;
      pullup_on_out = 1'b0;
    end else if (hold_in) begin
      pin_oe_out = held_dir_q;
      pin_out = held_lvl_q;
      pullup_on_out = !held_dir_q && pullup_control_bit_in;
    end else begin
      pin_oe_out = dir_in;
      pin_out = port_output_latch_in;
      pullup_on_out = !dir_in && pullup_control_bit_in;
    end
  end
endmodule // pss_pin_cell

/* pss_top.sv */
// port state control across reset, hardware/software standby, sleep and run
// assumes an axi4-lite master on core_clk_in; reset/standby pins are asynchronous
// What this block does
// - a held input pin floats, keeping its pull-up when direction is 0 and pull-up bit 1.
// - a held output pin keeps driving the level it had before low power was entered.
// - in sleep the address pins keep showing the last accessed address, except in single-chip mode, where they are not driven.
// - software standby resets shared peripherals while port pins keep the direction and level held at entry.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
module pss_top #(
  parameter int PORT_W = 8,
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // external reset and standby pins
  input wire logic chip_clear_n_in,
  input wire logic standby_pin_n_in,
  // address of the most recent bus access
  input wire logic [ADDR_W-1:0] bus_addr_in,
  input wire logic bus_access_in,
  // axi4-lite
  input wire logic [7:0] s_awaddr_in,
  input wire logic s_awvalid_in,
  output logic s_awready_out,
  input wire logic [31:0] s_wdata_in,
  input wire logic [3:0] s_wstrb_in,
  input wire logic s_wvalid_in,
  output logic s_wready_out,
  output logic [1:0] s_bresp_out,
  output logic s_bvalid_out,
  input wire logic s_bready_in,
  input wire logic [7:0] s_araddr_in,
  input wire logic s_arvalid_in,
  output logic s_arready_out,
  output logic [31:0] s_rdata_out,
  output logic [1:0] s_rresp_out,
  output logic s_rvalid_out,
  input wire logic s_rready_in,
  // pins
  output logic [PORT_W-1:0] gp_pin_out,
  output logic [PORT_W-1:0] gp_pin_oe_out,
  output logic [PORT_W-1:0] gp_pullup_out,
  output logic [ADDR_W-1:0] addr_pin_out,
  output logic addr_pin_oe_out,
  output logic sysclk_pin_out,
  output logic sysclk_pin_oe_out,
  output logic periph_reset_out,
  output logic hw_standby_out,
  output logic seq_violation_out
);
  import pss_pkg::*;

  logic res_s1_q, res_s2_q, stb_s1_q, stb_s2_q, stb_s3_q;
  logic [31:0] system_control_register_q;
  logic [PORT_W-1:0] dir_q, port_output_latch_q, pullup_control_bit_q;
  logic [ADDR_W-1:0] last_addr_q;
  pss_state_e state_q, state_d;
  logic [7:0] res_lead_q;
  logic aw_have_q, w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic viol_q;
  logic clk_div_q;

  // double flop the asynchronous pins
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      res_s1_q <= 1'b1;
      res_s2_q <= 1'b1;
      stb_s1_q <= 1'b1;
      stb_s2_q <= 1'b1;
      stb_s3_q <= 1'b1;
    end else begin
      res_s1_q <= chip_clear_n_in;
      res_s2_q <= res_s1_q;
      stb_s1_q <= standby_pin_n_in;
      stb_s2_q <= stb_s1_q;
      // edge found behind the second flop; the first may still be settling
      stb_s3_q <= stb_s2_q;
    end
  end

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  logic wr_fire;
  assign wr_fire = aw_have_q && w_have_q && !s_bvalid_out;
  logic mode_ext;
  assign mode_ext = system_control_register_q[CTRL_MODE_LSB +: 2] != PSS_MODE_SINGLE;

  // write channel: address and data taken in either order
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_bvalid_out <= 1'b0;
      s_bresp_out <= RESP_OKAY;
    end else begin
      if (s_awvalid_in && s_awready_out) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_awaddr_in;
      end
      if (s_wvalid_in && s_wready_out) begin
        w_have_q <= 1'b1;
        w_data_q <= s_wdata_in;
        w_strb_q <= s_wstrb_in;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_bvalid_out <= 1'b1;
        s_bresp_out <= (aw_addr_q <= ADDR_PULL && aw_addr_q[1:0] == 2'h0) ? RESP_OKAY
                                                                         : RESP_SLVERR;
      end else if (s_bvalid_out && s_bready_in) begin
        s_bvalid_out <= 1'b0;
      end
    end
  end
  assign s_awready_out = !aw_have_q && !s_bvalid_out;
  assign s_wready_out = !w_have_q && !s_bvalid_out;

  // software-written registers
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      system_control_register_q <= CTRL_RESET;
      dir_q <= '0;
      port_output_latch_q <= '0;
      pullup_control_bit_q <= '0;
    end else if (wr_fire) begin
      case (aw_addr_q)
        ADDR_CTRL: system_control_register_q <= wmerge(system_control_register_q, w_data_q,
                                                       w_strb_q);
        ADDR_DIR: dir_q <= PORT_W'(w_data_q);
        ADDR_DATA: port_output_latch_q <= PORT_W'(w_data_q);
        ADDR_PULL: pullup_control_bit_q <= PORT_W'(w_data_q);
        default: ;
      endcase
    end else if (state_q == PSS_SWSTBY) begin
      // wake from software standby is by software clearing the request
      system_control_register_q[CTRL_SLEEP_BIT] <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      s_rvalid_out <= 1'b0;
      s_rdata_out <= 32'h0000_0000;
      s_rresp_out <= RESP_OKAY;
    end else if (s_arvalid_in && s_arready_out) begin
      s_rvalid_out <= 1'b1;
      s_rresp_out <= RESP_OKAY;
      case (s_araddr_in)
        ADDR_CTRL: s_rdata_out <= system_control_register_q;
        ADDR_DIR: s_rdata_out <= 32'(dir_q);
        ADDR_DATA: s_rdata_out <= 32'(port_output_latch_q);
        ADDR_PULL: s_rdata_out <= 32'(pullup_control_bit_q);
        ADDR_STAT: s_rdata_out <= {28'h0, viol_q, 3'(state_q)};
        ADDR_ADDR: s_rdata_out <= 32'(last_addr_q);
        default: begin
          s_rdata_out <= 32'h0000_0000;
          s_rresp_out <= RESP_SLVERR;
        end
      endcase
    end else if (s_rvalid_out && s_rready_in) begin
      s_rvalid_out <= 1'b0;
    end
  end
  assign s_arready_out = !s_rvalid_out;

  // processing state
  always_comb begin
    state_d = state_q;
    case (state_q)
      PSS_HWSTBY: if (stb_s2_q) state_d = PSS_RESET;
      PSS_RESET: if (res_s2_q) state_d = PSS_RUN;
      PSS_SWSTBY: if (!system_control_register_q[CTRL_SSBY_BIT]) state_d = PSS_RUN;
      PSS_SLEEP: if (!system_control_register_q[CTRL_SLEEP_BIT]) state_d = PSS_RUN;
      PSS_RUN: begin
        if (system_control_register_q[CTRL_SSBY_BIT]) state_d = PSS_SWSTBY;
        else if (system_control_register_q[CTRL_SLEEP_BIT]) state_d = PSS_SLEEP;
      end
      default: state_d = PSS_RESET;
    endcase
    if (!stb_s2_q) state_d = PSS_HWSTBY;
    else if (!res_s2_q && state_q != PSS_HWSTBY) state_d = PSS_RESET;
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) state_q <= PSS_RESET;
    else state_q <= state_d;
  end

  // count reset-low lead before standby falls or rises; flag short entry leads with ram kept, short recovery leads always
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      res_lead_q <= 8'h00;
      viol_q <= 1'b0;
    end else begin
      if (res_s2_q) res_lead_q <= 8'h00;
      else if (res_lead_q != 8'hFF) res_lead_q <= res_lead_q + 8'h01;
      if (stb_s3_q && !stb_s2_q && system_control_register_q[CTRL_RAM_ENABLE_BIT_BIT] &&
          res_lead_q < 8'(RES_LEAD_CYCLES)) viol_q <= 1'b1;
      if (!stb_s3_q && stb_s2_q && res_lead_q < 8'(RECOV_LEAD_CYCLES))
        viol_q <= 1'b1;
    end
  end

  // last address tracking, frozen while sleeping
  always_ff @(posedge core_clk_in) begin
    if (rst_in) last_addr_q <= '0;
    else if (bus_access_in && state_q == PSS_RUN) last_addr_q <= bus_addr_in;
  end

  // output pins, all registered
  logic hold, flt;
  logic [PORT_W-1:0] c_pin, c_oe, c_pu;
  assign hold = state_q == PSS_SLEEP || state_q == PSS_SWSTBY;
  assign flt = state_q == PSS_HWSTBY || state_q == PSS_RESET;

  for (genvar g = 0; g < PORT_W; g++) begin : g_pin
    pss_pin_cell u_cell (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .dir_in(dir_q[g]),
      .port_output_latch_in(port_output_latch_q[g]),
      .pullup_control_bit_in(pullup_control_bit_q[g]),
      .hold_in(hold),
      .float_in(flt),
      .pin_out(c_pin[g]),
      .pin_oe_out(c_oe[g]),
      .pullup_on_out(c_pu[g])
    );
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      gp_pin_out <= '0;
      gp_pin_oe_out <= '0;
      gp_pullup_out <= '0;
      addr_pin_out <= '0;
      addr_pin_oe_out <= 1'b0;
      periph_reset_out <= 1'b1;
      hw_standby_out <= 1'b0;
      seq_violation_out <= 1'b0;
    end else begin
      gp_pin_out <= c_pin;
      gp_pin_oe_out <= c_oe;
      gp_pullup_out <= c_pu;
      addr_pin_out <= last_addr_q;
      addr_pin_oe_out <= mode_ext && (state_q == PSS_RUN || state_q == PSS_SLEEP);
      // peripherals cleared in reset, hardware standby and software standby
      periph_reset_out <= flt || state_q == PSS_SWSTBY;
      hw_standby_out <= state_q == PSS_HWSTBY;
      seq_violation_out <= viol_q;
    end
  end

  // clock pin: half rate divider, high in software standby
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      clk_div_q <= 1'b0;
      sysclk_pin_out <= 1'b0;
      sysclk_pin_oe_out <= 1'b0;
    end else begin
      clk_div_q <= !clk_div_q;
      sysclk_pin_out <= (state_q == PSS_SWSTBY) ? 1'b1 : clk_div_q;
      sysclk_pin_oe_out <= state_q != PSS_HWSTBY && (mode_ext || dir_q[0]);
    end
  end

  addr_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    state_q == PSS_SLEEP && $past(state_q) == PSS_SLEEP |-> $stable(last_addr_q))
    else $error("address changed in sleep");
  hw_float_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $past(state_q) == PSS_HWSTBY && state_q == PSS_HWSTBY |-> gp_pin_oe_out == '0 &&
    !addr_pin_oe_out && !sysclk_pin_oe_out) else $error("pin driven in hw standby");
  sw_clk_high_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    state_q == PSS_SWSTBY |=> sysclk_pin_out) else $error("clock not high");
  sw_periph_rst_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    state_q == PSS_SWSTBY |=> periph_reset_out) else $error("periph not reset");
  held_level_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    state_q == PSS_SLEEP && $past(state_q) == PSS_SLEEP ##1 state_q == PSS_SLEEP
    |-> $stable(gp_pin_out)) else $error("held level moved");
  pullup_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ##1 (gp_pullup_out & gp_pin_oe_out) == '0) else $error("pullup on output");
  stb_enter_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !stb_s2_q |=> state_q == PSS_HWSTBY) else $error("standby not entered");
  lead_flag_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    viol_q |=> viol_q) else $error("violation flag dropped");
endmodule // pss_top

/* pss_ext_sys.sv */
// external system model: drives the reset and standby pins of the block
// assumes the bench calls its tasks from one process, on core_clk_in
module pss_ext_sys (
  // clock
  input wire logic core_clk_in,
  // pins
  output logic chip_clear_n_out,
  output logic standby_pin_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    chip_clear_n_out = 1'b0;
    standby_pin_n_out = 1'b1;
  end
  // release of reset lands on the standby edge itself, the tightest legal case
  task automatic enter_hw(input bit keep_ram, input int lead);
    @(posedge core_clk_in);
    if (keep_ram) begin
      chip_clear_n_out <= 1'b0;
      repeat (lead) @(posedge core_clk_in);
    end
    standby_pin_n_out <= 1'b0;
    chip_clear_n_out <= 1'b1;
  endtask
  // reset stays low after standby rises until release_clear
  task automatic leave_hw(input int lead);
    @(posedge core_clk_in);
    chip_clear_n_out <= 1'b0;
    repeat (lead) @(posedge core_clk_in);
    standby_pin_n_out <= 1'b1;
  endtask
  task automatic release_clear();
    repeat (4) @(posedge core_clk_in);
    chip_clear_n_out <= 1'b1;
  endtask
endmodule // pss_ext_sys

/* port_state_standby_control_bench.sv */
// self-checking bench for the port state standby control block
// assumes pss_top with default widths and the pss_ext_sys pin model
module port_state_standby_control_bench import pss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ccn, sbn, bacc = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [15:0] baddr = 16'h0000;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic awr, wr, bv, arr, rv, aoe, sck, sck_oe, prst, hws, viol;
  logic [1:0] br, rr;
  logic [7:0] gp_pin, gp_oe, gp_pu;
  logic [15:0] apin;
  int err_total = 0;
  int comparisons = 0;
  logic [31:0] lfsr_q = 32'hC1AA;
  always #5 core_clk_in = ~core_clk_in;
  pss_ext_sys u_pss_ext_sys (.core_clk_in(core_clk_in), .chip_clear_n_out(ccn),
    .standby_pin_n_out(sbn));
  pss_top u_pss_top (.core_clk_in(core_clk_in), .rst_in(rst_in), .chip_clear_n_in(ccn),
    .standby_pin_n_in(sbn), .bus_addr_in(baddr), .bus_access_in(bacc), .s_awaddr_in(awa),
    .s_awvalid_in(awv), .s_awready_out(awr), .s_wdata_in(wd), .s_wstrb_in(4'hF),
    .s_wvalid_in(wv), .s_wready_out(wr), .s_bresp_out(br), .s_bvalid_out(bv),
    .s_bready_in(bry), .s_araddr_in(ara), .s_arvalid_in(arv), .s_arready_out(arr),
    .s_rdata_out(rd), .s_rresp_out(rr), .s_rvalid_out(rv), .s_rready_in(rry),
    .gp_pin_out(gp_pin), .gp_pin_oe_out(gp_oe), .gp_pullup_out(gp_pu), .addr_pin_out(apin),
    .addr_pin_oe_out(aoe), .sysclk_pin_out(sck), .sysclk_pin_oe_out(sck_oe),
    .periph_reset_out(prst), .hw_standby_out(hws), .seq_violation_out(viol));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // inputs float in hold, so only they may keep a pull-up
  function automatic logic [7:0] held_pu(input logic [7:0] dir, input logic [7:0] pul);
    return ~dir & pul;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // handshakes judged on values settled at the falling edge, acted on at the next rise
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    @(posedge core_clk_in);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    forever begin
      @(negedge core_clk_in);
      aw_t = awv & awr;
      w_t = wv & wr;
      b_t = bv;
      r = br;
      @(posedge core_clk_in);
      if (aw_t) awv <= 1'b0;
      if (w_t) wv <= 1'b0;
      if (b_t) begin
        bry <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    @(posedge core_clk_in);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    forever begin
      @(negedge core_clk_in);
      ar_t = arv & arr;
      r_t = rv;
      d = rd;
      r = rr;
      @(posedge core_clk_in);
      if (ar_t) arv <= 1'b0;
      if (r_t) begin
        rry <= 1'b0;
        break;
      end
    end
  endtask
  task automatic poll(input logic [2:0] st);
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 30; i++) begin
      axi_rd(ADDR_STAT, d, r);
      if (d[2:0] === st) break;
    end
    chk("state", 32'(st), 32'(d[2:0]));
  endtask
  initial begin
    repeat (20000) @(posedge core_clk_in);
    err_total++;
    end_sim();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] dir, dat, pul;
    logic [15:0] la;
    logic c0;
    repeat (8) @(posedge core_clk_in);
    rst_in <= 1'b0;
    axi_rd(ADDR_CTRL, d, r);
    chk("ctrl reset", CTRL_RESET, d);
    chk("reset float", 32'h0, 32'(gp_oe));
    axi_rd(8'h1C, d, r);
    chk("unmapped read", 32'(RESP_SLVERR), 32'(r));
    axi_wr(8'h18, 32'h0000_00FF, r);
    chk("unmapped write", 32'(RESP_SLVERR), 32'(r));
    u_pss_ext_sys.release_clear();
    poll(3'(PSS_RUN));
    // first pass is the corner: all inputs with every pull-up asked for
    for (int i = 0; i < 3; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      dir = (i == 0) ? 8'h00 : lfsr_q[7:0];
      dat = lfsr_q[15:8];
      pul = (i == 0) ? 8'hFF : lfsr_q[23:16];
      la = lfsr_q[15:0];
      axi_wr(ADDR_DIR, 32'(dir), r);
      axi_wr(ADDR_DATA, 32'(dat), r);
      axi_wr(ADDR_PULL, 32'(pul), r);
      baddr <= la;
      bacc <= 1'b1;
      @(posedge core_clk_in);
      bacc <= 1'b0;
      baddr <= ~la;
      axi_wr(ADDR_CTRL, 32'h0000_0014, r);
      poll(3'(PSS_SLEEP));
      // accesses while asleep must not move the address pins
      bacc <= 1'b1;
      @(negedge core_clk_in);
      chk("addr drive", 32'h1, 32'(aoe));
      chk("hold oe", 32'(dir), 32'(gp_oe));
      chk("hold level", 32'(dat & dir), 32'(gp_pin & dir));
      chk("hold pullup", 32'(held_pu(dir, pul)), 32'(gp_pu));
      c0 = sck;
      @(negedge core_clk_in);
      chk("sleep clock", 32'({1'b1, !c0}), 32'({sck_oe, sck}));
      axi_wr(ADDR_DATA, {24'h00, ~dat}, r);
      @(negedge core_clk_in);
      chk("addr hold", 32'(la), 32'(apin));
      chk("held after write", 32'(dat & dir), 32'(gp_pin & dir));
      dat = ~dat;
      @(posedge core_clk_in);
      bacc <= 1'b0;
      axi_wr(ADDR_CTRL, 32'h0000_0010, r);
      poll(3'(PSS_RUN));
      axi_wr(ADDR_CTRL, 32'h0000_0018, r);
      poll(3'(PSS_SWSTBY));
      chk("periph reset", 32'h1, 32'(prst));
      chk("port oe", 32'(dir), 32'(gp_oe));
      chk("port level", 32'(dat & dir), 32'(gp_pin & dir));
      chk("clock high", 32'h3, 32'({sck_oe, sck}));
      axi_wr(ADDR_CTRL, 32'h0000_0010, r);
      poll(3'(PSS_RUN));
    end
    // single-chip mode goes in without ram and without the reset lead
    for (int m = 0; m < 3; m++) begin
      axi_wr(ADDR_CTRL, (m == 2) ? 32'h0000_0002 : 32'h0000_0010 | 32'(m), r);
      u_pss_ext_sys.enter_hw(m != 2, RES_LEAD_CYCLES);
      repeat (6) @(posedge core_clk_in);
      chk("hw standby", 32'h1, 32'(hws));
      chk("pins float", 32'h0, 32'({gp_oe, aoe, sck_oe}));
      u_pss_ext_sys.leave_hw(RECOV_LEAD_CYCLES);
      u_pss_ext_sys.release_clear();
      poll(3'(PSS_RUN));
      chk("no violation", 32'h0, 32'(viol));
    end
    u_pss_ext_sys.enter_hw(1'b0, 0);
    repeat (6) @(posedge core_clk_in);
    u_pss_ext_sys.leave_hw(3);
    repeat (6) @(posedge core_clk_in);
    chk("short lead", 32'h1, 32'(viol));
    end_sim();
  end
endmodule // port_state_standby_control_bench
